//--- rtl/ncis_pkg.sv
// Operation
// - writing one clears a status flag; writing zero leaves it; reset-status flag excepted.
// - interrupt stays high while any unmasked flag is set.
// - every interrupt source can be masked individually by the mask register.
// - bit 0 sets on a packet received without error.
// - bit 1 sets on a packet transmitted without error.
// - bit 2 sets on CRC, alignment, overrun or missed-packet receive errors.
// - bit 3 sets on excessive collisions or transmit underrun.
// - bit 4 sets when the receive ring is exhausted.
// - bit 5 sets when any tally counter MSB becomes set.
// - bit 6 sets when a host DMA operation completes.
// - bit 7 sets on entering reset state, clears on a go command.
// - bit 7 also sets on ring overflow, clears when packets are removed.
// - host writes to the status register never alter the reset-status flag.
// - the reset-status flag never raises the interrupt.
// - mask bit one enables its same-position flag; zero disables it.
// - the mask register powers up all zero.
// - halt command enters reset state; completion shown by reset-status flag.
package ncis_pkg;

  // ==========================================================
  // register map (index, byte address is four times the index)
  localparam logic [7:0] CMD_IDX    = 8'h00;
  localparam logic [7:0] STATUS_IDX = 8'h07;
  localparam logic [7:0] MASK_IDX   = 8'h0F;
  localparam logic [7:0] CMD_ADDR    = {CMD_IDX[5:0], 2'b00};
  localparam logic [7:0] STATUS_ADDR = {STATUS_IDX[5:0], 2'b00};
  localparam logic [7:0] MASK_ADDR   = {MASK_IDX[5:0], 2'b00};

  // ==========================================================
  // status bit positions
  localparam int RX_OK_FLAG          = 0;
  localparam int TX_OK_FLAG          = 1;
  localparam int RX_FAULT_FLAG       = 2;
  localparam int TX_FAULT_FLAG       = 3;
  localparam int RING_FULL_FLAG      = 4;
  localparam int TALLY_OVERFLOW_FLAG = 5;
  localparam int HOST_DMA_DONE_FLAG  = 6;
  localparam int RESET_STATUS_FLAG   = 7;
  localparam int NUM_IRQ_FLAGS       = 7;

  // ==========================================================
  // command bits and reset values
  localparam int HALT_COMMAND = 0;
  localparam int GO_COMMAND   = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [6:0] MASK_RESET   = 7'h00;
  localparam logic       HALT_RESET   = 1'b1;
  localparam logic       GO_RESET     = 1'b0;

  // ==========================================================
  // event pulses from the controller's engines
  typedef struct packed {
    logic rxOk;
    logic txOk;
    logic rxCrcErr;
    logic rxAlignErr;
    logic rxOverrun;
    logic rxMissed;
    logic txExcessColl;
    logic txUnderrun;
    logic ringExhausted;
    logic dmaDone;
    logic ringOverflow;
    logic packetRemoved;
  } ncis_event_t;

endpackage : ncis_pkg

//--- rtl/ncis_apb_slave.sv
`timescale 1ns/1ps
module ncis_apb_slave #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // apb
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // register side
  input  wire logic [7:0]        cmdRd,
  input  wire logic [7:0]        statusRd,
  input  wire logic [7:0]        maskRd,
  output logic                   wrCmd,
  output logic                   wrStatus,
  output logic                   wrMask,
  output logic [7:0]             wrData
);

  // ==========================================================
  // decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] reg_addr);
    hit = (a == ADDR_W'(reg_addr));
  endfunction : hit

  logic access;
  logic mapped;
  logic [7:0] rdValue;

  assign access   = psel & penable;
  assign mapped   = hit(paddr, ncis_pkg::CMD_ADDR) | hit(paddr, ncis_pkg::STATUS_ADDR) |
                    hit(paddr, ncis_pkg::MASK_ADDR);
  // writes land at the edge where pready is sampled high
  assign wrCmd    = access & pready & pwrite & hit(paddr, ncis_pkg::CMD_ADDR);
  assign wrStatus = access & pready & pwrite & hit(paddr, ncis_pkg::STATUS_ADDR);
  assign wrMask   = access & pready & pwrite & hit(paddr, ncis_pkg::MASK_ADDR);
  assign wrData   = pwdata[7:0];

  always_comb begin
    rdValue = 8'h00;
    if (hit(paddr, ncis_pkg::CMD_ADDR)) begin
      rdValue = cmdRd;
    end else if (hit(paddr, ncis_pkg::STATUS_ADDR)) begin
      rdValue = statusRd;
    end else if (hit(paddr, ncis_pkg::MASK_ADDR)) begin
      rdValue = maskRd;
    end
  end

  // ==========================================================
  // one wait state, answer registered
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access & ~pready;
      if (access & ~pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdValue};
        pslverr <= ~mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule : ncis_apb_slave

//--- rtl/ncis_status.sv
`timescale 1ns/1ps
module ncis_status #(
  parameter int ADDR_W    = 8,
  parameter int NUM_TALLY = 3
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // apb
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // controller events
  input  wire ncis_pkg::ncis_event_t evIn,
  input  wire logic [NUM_TALLY-1:0]  tallyMsb,
  input  wire logic              engineIdle,
  // status outputs
  output logic                   irq,
  output logic                   offline,
  output logic                   haltCmd,
  output logic                   goCmd
);

  // ==========================================================
  // parameter checks
  generate
    if (ADDR_W < 8) begin : g_bad_addr
      $error("ADDR_W must be at least 8");
    end
    if (NUM_TALLY < 1) begin : g_bad_tally
      $error("NUM_TALLY must be at least 1");
    end
  endgenerate

  // ==========================================================
  // declarations
  logic [7:0]           status_reg;
  logic [7:0]           status_next;
  logic [6:0]           mask_reg;
  logic [NUM_TALLY-1:0] tallyPrev_reg;
  logic [7:0]           setVec;
  logic [7:0]           clrVec;
  logic                 wrCmd;
  logic                 wrStatus;
  logic                 wrMask;
  logic [7:0]           wrData;
  logic                 rxFault;
  logic                 txFault;
  logic                 tallyRise;
  logic                 enterOffline;
  logic                 goStart;
  logic                 rstSet;
  logic                 rstClr;
  logic                 offline_next;

  // ==========================================================
  // bus slave
  ncis_apb_slave #(
    .ADDR_W (ADDR_W)
  ) u_apb (
    .clk      (clk),
    .reset_n  (reset_n),
    .paddr    (paddr),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .pwdata   (pwdata),
    .pready   (pready),
    .prdata   (prdata),
    .pslverr  (pslverr),
    .cmdRd    ({6'h00, goCmd, haltCmd}),
    .statusRd (status_reg),
    .maskRd   ({1'b0, mask_reg}),
    .wrCmd    (wrCmd),
    .wrStatus (wrStatus),
    .wrMask   (wrMask),
    .wrData   (wrData)
  );

  // ==========================================================
  // event gathering
  // receive error causes
  assign rxFault   = evIn.rxCrcErr | evIn.rxAlignErr | evIn.rxOverrun | evIn.rxMissed;
  assign txFault   = evIn.txExcessColl | evIn.txUnderrun;
  assign tallyRise = |(tallyMsb & ~tallyPrev_reg);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tallyPrev_reg <= '0;
    end else begin
      tallyPrev_reg <= tallyMsb;
    end
  end

  always_comb begin
    setVec = 8'h00;
    setVec[ncis_pkg::RX_OK_FLAG]          = evIn.rxOk;
    setVec[ncis_pkg::TX_OK_FLAG]          = evIn.txOk;
    setVec[ncis_pkg::RX_FAULT_FLAG]       = rxFault;
    setVec[ncis_pkg::TX_FAULT_FLAG]       = txFault;
    setVec[ncis_pkg::RING_FULL_FLAG]      = evIn.ringExhausted;
    setVec[ncis_pkg::TALLY_OVERFLOW_FLAG] = tallyRise;
    setVec[ncis_pkg::HOST_DMA_DONE_FLAG]  = evIn.dmaDone;
    setVec[ncis_pkg::RESET_STATUS_FLAG]   = rstSet;
  end

  // ==========================================================
  // command register and reset state
  // go command detect
  assign goStart      = wrCmd & wrData[ncis_pkg::GO_COMMAND] & ~wrData[ncis_pkg::HALT_COMMAND];
  // halt enters reset state once idle
  assign offline_next = offline ? ~(~haltCmd & goCmd) : (haltCmd & engineIdle);
  assign enterOffline = offline_next & ~offline;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      haltCmd <= ncis_pkg::HALT_RESET;
      goCmd   <= ncis_pkg::GO_RESET;
    end else if (wrCmd) begin
      haltCmd <= wrData[ncis_pkg::HALT_COMMAND];
      goCmd   <= wrData[ncis_pkg::GO_COMMAND];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      offline <= 1'b0;
    end else begin
      offline <= offline_next;
    end
  end

  // ==========================================================
  // status flags
  // reset state and go command
  assign rstSet = enterOffline | evIn.ringOverflow;
  assign rstClr = goStart | evIn.packetRemoved;

  genvar gi;
  generate
    for (gi = 0; gi < ncis_pkg::NUM_IRQ_FLAGS; gi++) begin : g_flag
      assign clrVec[gi]      = wrStatus & wrData[gi];
      assign status_next[gi] = setVec[gi] | (status_reg[gi] & ~clrVec[gi]);
    end
  endgenerate

  // host write ignored for reset status
  assign clrVec[ncis_pkg::RESET_STATUS_FLAG]      = rstClr;
  assign status_next[ncis_pkg::RESET_STATUS_FLAG] = setVec[ncis_pkg::RESET_STATUS_FLAG] |
    (status_reg[ncis_pkg::RESET_STATUS_FLAG] & ~clrVec[ncis_pkg::RESET_STATUS_FLAG]);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status_reg <= ncis_pkg::STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // ==========================================================
  // mask and interrupt
  // mask powers up zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mask_reg <= ncis_pkg::MASK_RESET;
    end else if (wrMask) begin
      mask_reg <= wrData[6:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg[6:0] & mask_reg);
    end
  end

  // ==========================================================
  // checks
  property p_clear_one;
    @(posedge clk) disable iff (!reset_n)
    wrStatus |=> ((status_reg[6:0] & $past(wrData[6:0]) & ~$past(setVec[6:0])) == 7'h00);
  endproperty
  a_clear_one: assert property (p_clear_one)
    else $error("status flag not cleared by write of one");

  property p_keep_zero;
    @(posedge clk) disable iff (!reset_n)
    wrStatus |=> ((($past(status_reg[6:0]) & ~$past(wrData[6:0])) & ~status_reg[6:0]) == 7'h00);
  endproperty
  a_keep_zero: assert property (p_keep_zero)
    else $error("status flag lost on write of zero");

  property p_irq_level;
    @(posedge clk) disable iff (!reset_n)
    ##1 (irq == |($past(status_reg[6:0]) & $past(mask_reg)));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt does not follow masked flags");

  property p_masked_quiet;
    @(posedge clk) disable iff (!reset_n)
    (mask_reg == 7'h00) [*2] |-> !irq;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("interrupt raised with all sources masked");

  property p_rx_ok;
    @(posedge clk) disable iff (!reset_n)
    evIn.rxOk |=> status_reg[ncis_pkg::RX_OK_FLAG] ##1 (irq || !mask_reg[ncis_pkg::RX_OK_FLAG] || !reset_n);
  endproperty
  a_rx_ok: assert property (p_rx_ok)
    else $error("receive ok flag or interrupt missing");

  property p_rx_fault;
    @(posedge clk) disable iff (!reset_n)
    rxFault |=> status_reg[ncis_pkg::RX_FAULT_FLAG];
  endproperty
  a_rx_fault: assert property (p_rx_fault)
    else $error("receive fault flag not set");

  property p_tx_fault;
    @(posedge clk) disable iff (!reset_n)
    (evIn.txExcessColl || evIn.txUnderrun) |=> status_reg[ncis_pkg::TX_FAULT_FLAG];
  endproperty
  a_tx_fault: assert property (p_tx_fault)
    else $error("transmit fault flag not set");

  property p_dma_done;
    @(posedge clk) disable iff (!reset_n)
    evIn.dmaDone |=> status_reg[ncis_pkg::HOST_DMA_DONE_FLAG];
  endproperty
  a_dma_done: assert property (p_dma_done)
    else $error("dma done flag not set");

  property p_go_clears;
    @(posedge clk) disable iff (!reset_n)
    (goStart && !rstSet) |=> !status_reg[ncis_pkg::RESET_STATUS_FLAG];
  endproperty
  a_go_clears: assert property (p_go_clears)
    else $error("go command did not clear reset status");

  property p_overflow_sets;
    @(posedge clk) disable iff (!reset_n)
    evIn.ringOverflow |=> status_reg[ncis_pkg::RESET_STATUS_FLAG];
  endproperty
  a_overflow_sets: assert property (p_overflow_sets)
    else $error("ring overflow did not set reset status");

  property p_write_no_effect;
    @(posedge clk) disable iff (!reset_n)
    (wrStatus && !rstSet && !rstClr) |=> $stable(status_reg[ncis_pkg::RESET_STATUS_FLAG]);
  endproperty
  a_write_no_effect: assert property (p_write_no_effect)
    else $error("host write altered reset status");

  property p_rst_no_irq;
    @(posedge clk) disable iff (!reset_n)
    (status_reg[6:0] == 7'h00) [*2] |-> !irq;
  endproperty
  a_rst_no_irq: assert property (p_rst_no_irq)
    else $error("interrupt without unmasked low flag");

  property p_mask_reset;
    @(posedge clk)
    $rose(reset_n) |-> (mask_reg == 7'h00);
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("mask not zero after reset");

  property p_halt_done;
    @(posedge clk) disable iff (!reset_n)
    (reset_n && haltCmd && !goCmd && engineIdle && !offline && !wrCmd) |=>
      offline && status_reg[ncis_pkg::RESET_STATUS_FLAG];
  endproperty
  a_halt_done: assert property (p_halt_done)
    else $error("halt did not signal reset status");

endmodule : ncis_status

//--- verification/ncis_host_model.sv
`timescale 1ns/1ps
module ncis_host_model (
  // clock
  input  wire logic        clk,
  // apb master
  output logic [7:0]       paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial begin
    paddr   = 8'h00;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h00000000;
  end

  // ==========================================================
  // one transfer, request held until pready is sampled high
  task automatic xfer(input logic [7:0] addr, input logic wr, input logic [7:0] data,
                      output logic [7:0] rdata, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= addr;
    pwrite  <= wr;
    pwdata  <= {24'h000000, data};
    @(posedge clk);
    penable <= 1'b1;
    // only the bench watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata[7:0];
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines no longer show the old request
    paddr   <= ~addr;
    pwdata  <= {24'hFFFFFF, ~data};
  endtask : xfer
endmodule : ncis_host_model

//--- verification/test_net_ctrl_interrupt_status.sv
`timescale 1ns/1ps
module test_net_ctrl_interrupt_status;
  // ==========================================================
  // signals
  logic                  clk;
  logic                  reset_n;
  logic [7:0]            paddr;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [31:0]           pwdata;
  logic                  pready;
  logic [31:0]           prdata;
  logic                  pslverr;
  ncis_pkg::ncis_event_t evIn;
  logic [2:0]            tallyMsb;
  logic                  engineIdle;
  logic                  irq;
  logic                  offline;
  logic                  haltCmd;
  logic                  goCmd;
  int                    errTotal;
  int                    checkCount;
  logic [7:0]            rdVal;
  logic                  rdErr;
  int                    bitOf [10] = '{0, 1, 2, 2, 2, 2, 3, 3, 4, 6};

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ncis_host_model host (.clk(clk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
                        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  ncis_status dut (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
                   .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
                   .evIn(evIn), .tallyMsb(tallyMsb), .engineIdle(engineIdle), .irq(irq),
                   .offline(offline), .haltCmd(haltCmd), .goCmd(goCmd));

  // ==========================================================
  // compares and bus tasks
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(a, 1'b1, d, rdVal, rdErr);
    chk_bit(rdErr, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.xfer(a, 1'b0, 8'h00, rdVal, rdErr);
    chk_val(rdVal, exp);
  endtask : rd

  task automatic irq_is(input logic exp);
    repeat (2) @(negedge clk);
    chk_bit(irq, exp);
  endtask : irq_is

  task automatic pulse(input int k);
    @(posedge clk);
    evIn <= ncis_pkg::ncis_event_t'(12'h800 >> k);
    @(posedge clk);
    evIn <= ncis_pkg::ncis_event_t'(12'h000);
  endtask : pulse

  task report_and_stop;
    $display("errors=%0d checks=%0d", errTotal, checkCount);
    if (errTotal == 0 && checkCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #200000;
    errTotal++;
    report_and_stop();
  end

  // ==========================================================
  // tests
  initial begin
    reset_n    = 1'b0;
    evIn       = ncis_pkg::ncis_event_t'(12'h000);
    tallyMsb   = 3'b000;
    engineIdle = 1'b1;
    errTotal   = 0;
    checkCount = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd(ncis_pkg::MASK_ADDR, 8'h00);
    rd(ncis_pkg::STATUS_ADDR, 8'h80);
    @(negedge clk);
    chk_bit(offline, 1'b1);
    wr(ncis_pkg::STATUS_ADDR, 8'hFF);
    rd(ncis_pkg::STATUS_ADDR, 8'h80);
    wr(ncis_pkg::CMD_ADDR, 8'h02);
    rd(ncis_pkg::STATUS_ADDR, 8'h00);
    @(negedge clk);
    chk_bit(offline, 1'b0);
    chk_bit(goCmd, 1'b1);
    wr(ncis_pkg::MASK_ADDR, 8'hFF);
    rd(ncis_pkg::MASK_ADDR, 8'h7F);
    for (int k = 0; k < 10; k++) begin
      pulse(k);
      rd(ncis_pkg::STATUS_ADDR, 8'h01 << bitOf[k]);
      irq_is(1'b1);
      wr(ncis_pkg::STATUS_ADDR, 8'h01 << bitOf[k]);
      irq_is(1'b0);
      rd(ncis_pkg::STATUS_ADDR, 8'h00);
    end
    @(posedge clk);
    tallyMsb <= 3'b100;
    rd(ncis_pkg::STATUS_ADDR, 8'h20);
    irq_is(1'b1);
    wr(ncis_pkg::STATUS_ADDR, 8'h20);
    tallyMsb <= 3'b000;
    rd(ncis_pkg::STATUS_ADDR, 8'h00);
    wr(ncis_pkg::MASK_ADDR, 8'h7E);
    pulse(0);
    rd(ncis_pkg::STATUS_ADDR, 8'h01);
    irq_is(1'b0);
    pulse(1);
    irq_is(1'b1);
    wr(ncis_pkg::MASK_ADDR, 8'h7F);
    wr(ncis_pkg::STATUS_ADDR, 8'h00);
    rd(ncis_pkg::STATUS_ADDR, 8'h03);
    wr(ncis_pkg::STATUS_ADDR, 8'h01);
    irq_is(1'b1);
    wr(ncis_pkg::STATUS_ADDR, 8'h02);
    irq_is(1'b0);
    pulse(10);
    rd(ncis_pkg::STATUS_ADDR, 8'h80);
    irq_is(1'b0);
    pulse(11);
    rd(ncis_pkg::STATUS_ADDR, 8'h00);
    @(posedge clk);
    engineIdle <= 1'b0;
    wr(ncis_pkg::CMD_ADDR, 8'h01);
    rd(ncis_pkg::STATUS_ADDR, 8'h00);
    @(negedge clk);
    chk_bit(offline, 1'b0);
    @(posedge clk);
    engineIdle <= 1'b1;
    rd(ncis_pkg::STATUS_ADDR, 8'h80);
    rd(ncis_pkg::CMD_ADDR, 8'h01);
    @(negedge clk);
    chk_bit(offline, 1'b1);
    chk_bit(haltCmd, 1'b1);
    // go with halt still set must not restart the controller
    wr(ncis_pkg::CMD_ADDR, 8'h03);
    rd(ncis_pkg::STATUS_ADDR, 8'h80);
    rd(ncis_pkg::CMD_ADDR, 8'h03);
    @(negedge clk);
    chk_bit(offline, 1'b1);
    host.xfer(8'h04, 1'b0, 8'h00, rdVal, rdErr);
    chk_bit(rdErr, 1'b1);
    chk_val(rdVal, 8'h00);
    report_and_stop();
  end
endmodule : test_net_ctrl_interrupt_status
